// [core/lic_line_ctrl.sv]
// line interface control port: serial register, pin control, line logic
`timescale 1ns/100ps
`default_nettype none
module lic_line_ctrl #(
  parameter int DPM_TIMEOUT = lic_pkg::DPM_TIMEOUT
) (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // mode and gated control pins
  input  wire logic        pin_mode_ext_i,
  input  wire logic        ctrl_latch_en_n_i,
  input  wire logic        tx_coder_sel_i,
  input  wire logic        rx_decoder_sel_i,
  input  wire logic [2:0]  cable_sel_i,
  input  wire logic        remote_loop_i,
  input  wire logic        local_loop_i,
  input  wire logic        tx_all_ones_i,
  // serial host port
  input  wire logic        ser_clk_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        serial_in_i,
  input  wire logic        out_edge_sel_i,
  output logic             serial_out_o,
  output logic             serial_oe_o,
  output logic             int_n_out_o,
  output logic             int_n_oe_o,
  // line side
  input  wire logic        line_clk_i,
  input  wire logic        tx_nrz_in_i,
  input  wire logic        line_in_p_i,
  input  wire logic        line_in_n_i,
  input  wire logic        mon_pos_in_i,
  input  wire logic        mon_neg_in_i,
  output logic             line_out_p_o,
  output logic             line_out_n_o,
  output logic             rx_pos_out_o,
  output logic             rx_neg_out_o,
  output logic             rx_nrz_out_o,
  output logic             violation_strobe_o,
  output logic             alarm_ind_out_o,
  output logic             no_signal_flag_o,
  output logic             driver_fail_flag_o,
  output lic_pkg::lic_code_t tx_code_o,
  output lic_pkg::lic_code_t rx_code_o
);

  // line code chosen from select and cable bits
  function automatic lic_pkg::lic_code_t code_of(input logic ami,
                                                 input logic [2:0] cab);
    if (ami)
      code_of = lic_pkg::LIC_CODE_AMI;
    else if (cab == 3'h0)
      code_of = lic_pkg::LIC_CODE_HDB3;
    else if (cab[2:1] != 2'h0)
      code_of = lic_pkg::LIC_CODE_B8ZS;
    else
      code_of = lic_pkg::LIC_CODE_AMI;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers into clk_i
  localparam int NPIN = 14;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m;
  logic [NPIN-1:0] pin_s;
  assign pin_raw = {ser_clk_i, chip_select_n_i, serial_in_i, out_edge_sel_i,
                    pin_mode_ext_i, ctrl_latch_en_n_i, tx_coder_sel_i,
                    rx_decoder_sel_i, cable_sel_i, remote_loop_i,
                    local_loop_i, tx_all_ones_i};
  always_ff @(posedge clk_i)
  begin
    pin_m <= pin_raw;
    pin_s <= pin_m;
  end
  logic sck_s, cs_s, sdi_s, edge_sel, ext_mode, latch_n;
  assign sck_s    = pin_s[13];
  assign cs_s     = pin_s[12];
  assign sdi_s    = pin_s[11];
  assign edge_sel = pin_s[10];
  assign ext_mode = pin_s[9];
  assign latch_n  = pin_s[8];

  // edges of serial clock and select
  logic sck_d, cs_d;
  always_ff @(posedge clk_i)
  begin
    sck_d <= sck_s;
    cs_d  <= cs_s;
  end
  logic sck_rise, sck_fall, cs_fall;
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign cs_fall  = cs_d & ~cs_s;

  //////////////////////////////////////////////////////////////////////////
  // serial frame sequencer, runs on clk_i only [R12]
  lic_pkg::lic_sp_t state;
  logic [4:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic       commit;
  assign next_shreg = {sdi_s, shreg[7:1]}; // lsb arrives first [R16]
  assign commit = (state == lic_pkg::LIC_SP_WR) && sck_rise && !cs_s &&
                  (bitcnt == lic_pkg::DATA_LAST_BIT); // [R27]
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cs_s)
    begin
      state  <= lic_pkg::LIC_SP_IDLE;
      bitcnt <= 5'h00;
      shreg  <= 8'h00;
    end
    else
    begin
      case (state)
        lic_pkg::LIC_SP_IDLE:
          if (cs_fall) // [R13]
          begin
            state  <= lic_pkg::LIC_SP_CMD;
            bitcnt <= 5'h00;
          end
        lic_pkg::LIC_SP_CMD:
          if (sck_rise) // [R13]
          begin
            shreg  <= next_shreg;
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == lic_pkg::CMD_LAST_BIT)
            begin
              // address in bits 6:1, bit 7 ignored [R16]
              if (next_shreg[6:1] != lic_pkg::REG_ADDR)
                state <= lic_pkg::LIC_SP_SKIP;
              else if (next_shreg[0])
                state <= lic_pkg::LIC_SP_RD;
              else
                state <= lic_pkg::LIC_SP_WR;
            end
          end
        lic_pkg::LIC_SP_WR:
          if (sck_rise) // [R17]
          begin
            shreg  <= next_shreg;
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == lic_pkg::DATA_LAST_BIT)
              state <= lic_pkg::LIC_SP_SKIP;
          end
        lic_pkg::LIC_SP_RD:
          if (sck_rise && bitcnt != 5'h1F)
            bitcnt <= bitcnt + 5'h01;
        lic_pkg::LIC_SP_SKIP:
          bitcnt <= bitcnt;
        default:
          state <= lic_pkg::LIC_SP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // host register and interrupt masks
  lic_pkg::lic_ctrl_t host_ctrl;
  logic mask_nosig, mask_drv;
  logic both_loops, test_req;
  // remote loop plus all ones is the test request, not a reset [R20]
  assign test_req   = next_shreg[lic_pkg::WB_REMOTE_LOOP] &
                      next_shreg[lic_pkg::WB_ALL_ONES];
  assign both_loops = next_shreg[lic_pkg::WB_REMOTE_LOOP] &
                      next_shreg[lic_pkg::WB_LOCAL_LOOP] & ~test_req;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (commit && both_loops)) // [R25]
    begin
      host_ctrl  <= lic_pkg::CTRL_RESET;
      mask_nosig <= 1'b0;
      mask_drv   <= 1'b0;
    end
    else if (commit)
    begin
      host_ctrl.cable    <= next_shreg[lic_pkg::WB_CABLE +: 3]; // [R17]
      host_ctrl.remote_loop    <= next_shreg[lic_pkg::WB_REMOTE_LOOP];      // [R1]
      host_ctrl.local_loop    <= next_shreg[lic_pkg::WB_LOCAL_LOOP] & ~test_req;
      host_ctrl.all_ones <= next_shreg[lic_pkg::WB_ALL_ONES];   // [R20]
      // one masks the source, zero enables it [R18] [R19]
      mask_nosig <= next_shreg[lic_pkg::WB_CLR_NOSIG];
      mask_drv   <= next_shreg[lic_pkg::WB_CLR_DRV];
    end
  end

  // gated control pins, follow only while enable low [R9]
  lic_pkg::lic_ctrl_t pin_ctrl;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_ctrl <= lic_pkg::CTRL_RESET;
    else if (!latch_n)
      pin_ctrl <= '{pin_s[0], pin_s[1], pin_s[2], pin_s[5:3],
                    pin_s[7], pin_s[6]};
  end

  // effective control, registered before the crossing [R1]
  lic_pkg::lic_ctrl_t eff_ctrl;
  logic               eff_ext;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      eff_ctrl <= lic_pkg::CTRL_RESET;
      eff_ext  <= 1'b0;
    end
    else
    begin
      eff_ctrl <= ext_mode ? pin_ctrl : host_ctrl;
      eff_ext  <= ext_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status flags crossing back from the line domain
  logic no_sig_l, drv_fail_l;
  logic [1:0] st_m, st_s, st_d;
  always_ff @(posedge clk_i)
  begin
    st_m <= {no_sig_l, drv_fail_l};
    st_s <= st_m;
    st_d <= st_s;
  end
  logic nosig_edge, drv_edge;
  assign nosig_edge = st_s[1] ^ st_d[1];
  assign drv_edge   = st_s[0] ^ st_d[0];

  // change flags, a change in the clearing cycle wins [R18]
  logic chg_nosig, chg_drv;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (commit && both_loops))
    begin
      chg_nosig <= 1'b0;
      chg_drv   <= 1'b0;
    end
    else
    begin
      if (nosig_edge)
        chg_nosig <= 1'b1;
      else if (commit && next_shreg[lic_pkg::WB_CLR_NOSIG])
        chg_nosig <= 1'b0;
      if (drv_edge)
        chg_drv <= 1'b1;
      else if (commit && next_shreg[lic_pkg::WB_CLR_DRV])
        chg_drv <= 1'b0;
    end
  end

  // open-drain interrupt, low on unmasked change [R24]
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      int_n_oe_o <= 1'b0;
    else
      int_n_oe_o <= (chg_nosig & ~mask_nosig) | (chg_drv & ~mask_drv);
  end
  assign int_n_out_o = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // read word, snapshot at the end of the command byte
  logic [2:0] mode_bits;
  always_comb
  begin
    // bit order {b7, b6, b5} [R22]
    if (chg_nosig || chg_drv)
      mode_bits = {chg_drv, chg_nosig, 1'b1};
    else if (host_ctrl.remote_loop)
      mode_bits = 3'h1;
    else
      mode_bits = {host_ctrl.all_ones, host_ctrl.local_loop, 1'b0};
  end
  logic [7:0] rd_word;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_word <= 8'h00;
    else if (state == lic_pkg::LIC_SP_CMD && sck_rise &&
             bitcnt == lic_pkg::CMD_LAST_BIT)
      rd_word <= {mode_bits, host_ctrl.cable, st_s[0], st_s[1]}; // [R21]
  end

  // output driver: change on edge opposite the valid edge [R23]
  logic out_ev;
  assign out_ev = edge_sel ? sck_fall : sck_rise;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cs_s || state != lic_pkg::LIC_SP_RD)
    begin
      serial_out_o <= 1'b0;
      serial_oe_o  <= 1'b0;
    end
    else if (out_ev && bitcnt >= lic_pkg::DATA_FIRST &&
             bitcnt < lic_pkg::OUT_END_CNT)
    begin
      serial_out_o <= rd_word[bitcnt[2:0]];
      serial_oe_o  <= 1'b1;
    end
    else if (out_ev && bitcnt == lic_pkg::OUT_END_CNT)
      serial_oe_o <= 1'b0; // release after last bit hold [R15]
  end

  //////////////////////////////////////////////////////////////////////////
  // line domain: reset and control synchronisers
  logic lrst_m, lrst;
  always_ff @(posedge line_clk_i)
  begin
    lrst_m <= rst_i;
    lrst   <= lrst_m;
  end
  // quasi-static control word, settles within four line clocks
  lic_pkg::lic_ctrl_t lc_m, lc_s, lc_d, lc;
  logic lext_m, lext;
  logic [1:0] mon_m, mon_s;
  always_ff @(posedge line_clk_i)
  begin
    lc_m   <= eff_ctrl;
    lc_s   <= lc_m;
    lc_d   <= lc_s;
    // word taken only once two samples agree, no torn bits
    if (lc_s == lc_d)
      lc <= lc_s;
    lext_m <= eff_ext;
    lext   <= lext_m;
    mon_m  <= {mon_pos_in_i, mon_neg_in_i};
    mon_s  <= mon_m;
  end

  // transmit source and AMI encoder [R3] [R8]
  logic tx_mark, tx_pol;
  assign tx_mark = lc.all_ones | tx_nrz_in_i;
  always_ff @(posedge line_clk_i)
  begin
    if (lrst)
    begin
      line_out_p_o <= 1'b0;
      line_out_n_o <= 1'b0;
      tx_pol       <= 1'b0;
    end
    else if (lc.remote_loop)
    begin
      // raw loop ahead of the coder keeps violations [R2] [R5]
      line_out_p_o <= line_in_p_i;
      line_out_n_o <= line_in_n_i;
    end
    else
    begin
      line_out_p_o <= tx_mark & ~tx_pol;
      line_out_n_o <= tx_mark & tx_pol;
      if (tx_mark)
        tx_pol <= ~tx_pol;
    end
  end

  // receive outputs and decoder, local loop feeds transmit back
  logic rx_p, rx_n, rx_mark, last_pol;
  assign rx_p    = lc.local_loop ? line_out_p_o : line_in_p_i;
  assign rx_n    = lc.local_loop ? line_out_n_o : line_in_n_i;
  assign rx_mark = rx_p | rx_n;
  always_ff @(posedge line_clk_i)
  begin
    if (lrst)
    begin
      rx_pos_out_o       <= 1'b0;
      rx_neg_out_o       <= 1'b0;
      rx_nrz_out_o       <= 1'b0;
      violation_strobe_o <= 1'b0;
      last_pol           <= 1'b1;
    end
    else
    begin
      rx_pos_out_o       <= rx_p; // [R2]
      rx_neg_out_o       <= rx_n;
      rx_nrz_out_o       <= rx_mark; // [R5] [R8]
      violation_strobe_o <= rx_mark && (rx_n == last_pol);
      if (rx_mark)
        last_pol <= rx_n;
    end
  end

  // coder selection [R7]
  always_ff @(posedge line_clk_i)
  begin
    if (lrst)
    begin
      tx_code_o <= lic_pkg::LIC_CODE_AMI;
      rx_code_o <= lic_pkg::LIC_CODE_AMI;
    end
    else
    begin
      tx_code_o <= code_of(lc.tx_ami | ~lext, lc.cable);
      rx_code_o <= code_of(lc.rx_ami | ~lext, lc.cable);
    end
  end

  // alarm indication: zeros per 2048-bit window [R6]
  logic [10:0] ais_cnt;
  logic [1:0]  ais_zeros;
  always_ff @(posedge line_clk_i)
  begin
    if (lrst)
    begin
      ais_cnt         <= 11'h000;
      ais_zeros       <= 2'h0;
      alarm_ind_out_o <= 1'b0;
    end
    else
    begin
      ais_cnt <= ais_cnt + 11'h001;
      if (ais_cnt == lic_pkg::AIS_WIN_LAST)
      begin
        alarm_ind_out_o <= lext && ({1'b0, ais_zeros} + {2'b00, ~rx_mark})
                           < {1'b0, lic_pkg::AIS_MIN_ZEROS};
        ais_zeros <= 2'h0;
      end
      else if (!rx_mark && ais_zeros != lic_pkg::AIS_MIN_ZEROS)
        ais_zeros <= ais_zeros + 2'h1;
      if (!lext)
        alarm_ind_out_o <= 1'b0;
    end
  end

  // loss of signal: long zero run sets, ones in window clear
  logic [7:0] zrun;
  logic [4:0] los_win;
  logic [1:0] los_ones;
  always_ff @(posedge line_clk_i)
  begin
    if (lrst)
    begin
      zrun     <= 8'h00;
      los_win  <= 5'h00;
      los_ones <= 2'h0;
      no_sig_l <= 1'b1;
    end
    else
    begin
      zrun <= rx_mark ? 8'h00 : (zrun == 8'hFF ? zrun : zrun + 8'h01);
      los_win <= los_win + 5'h01;
      if (!no_sig_l)
      begin
        if (!rx_mark && zrun == lic_pkg::LOS_ZERO_RUN - 8'h01)
          no_sig_l <= 1'b1;
        los_ones <= 2'h0;
      end
      else if (los_win == lic_pkg::LOS_WIN_LAST ||
               zrun > {4'h0, lic_pkg::LOS_MAX_RUN})
        los_ones <= 2'h0;
      else if (rx_mark)
      begin
        los_ones <= los_ones + 2'h1;
        if (los_ones == lic_pkg::LOS_ONES - 2'h1)
          no_sig_l <= 1'b0;
      end
    end
  end

  // driver monitor: activity time-out restarts on crossing [R26]
  localparam int TW = $clog2(DPM_TIMEOUT + 1);
  logic          act_d, crossing;
  logic [TW-1:0] dpm_cnt;
  assign crossing = (mon_s[1] | mon_s[0]) & ~act_d;
  always_ff @(posedge line_clk_i)
  begin
    if (lrst)
    begin
      act_d      <= 1'b0;
      dpm_cnt    <= '0;
      drv_fail_l <= 1'b0;
    end
    else
    begin
      act_d <= mon_s[1] | mon_s[0];
      if (crossing)
      begin
        dpm_cnt    <= '0;
        drv_fail_l <= 1'b0; // [R11]
      end
      else if (dpm_cnt == TW'(DPM_TIMEOUT - 1))
        drv_fail_l <= 1'b1; // [R11]
      else
        dpm_cnt <= dpm_cnt + 1'b1;
    end
  end
  assign no_signal_flag_o   = no_sig_l;
  assign driver_fail_flag_o = drv_fail_l;

  //////////////////////////////////////////////////////////////////////////
  // checks
  chk_all_ones_tx: assert property (@(posedge line_clk_i) disable iff (lrst)
    (!lc.remote_loop && lc.all_ones) |=> (line_out_p_o ^ line_out_n_o)) // [R3]
    else $error("all ones source not sent");
  chk_remote_loop: assert property (@(posedge line_clk_i) disable iff (lrst)
    lc.remote_loop |=> (line_out_p_o == $past(line_in_p_i))) // [R2]
    else $error("remote loop data not retransmitted");
  chk_alarm_host: assert property (@(posedge line_clk_i) disable iff (lrst)
    (!lext && $past(!lext)) |-> !alarm_ind_out_o) // [R6]
    else $error("alarm outside extended mode");
  chk_dpm_restart: assert property (@(posedge line_clk_i) disable iff (lrst)
    crossing |=> (!drv_fail_l && dpm_cnt == '0)) // [R26]
    else $error("time-out not restarted");
  chk_int_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_drv && !chg_nosig) |=> !int_n_oe_o) // [R18]
    else $error("masked interrupt asserted");
  chk_abort_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == lic_pkg::LIC_SP_WR && !commit) |=> $stable(host_ctrl)) // [R27]
    else $error("register changed before eight bits");
  chk_sdo_release: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_s |=> !serial_oe_o) // [R15]
    else $error("output driven while deselected");
  chk_gate_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    latch_n |=> $stable(pin_ctrl)) // [R9]
    else $error("gated pins taken while disabled");

endmodule
`default_nettype wire

// [pkg/lic_pkg.sv]
// package: constants, types and serial register layout of the line control port
// Operation
// (R1) remote loop from pin or register bit
// (R2) looped receive data also reaches receive outputs
// (R3) line source: input data, all ones, or loop
// (R4) host never selects both loopbacks as mode
// (R5) extended remote loop bypasses coder, keeps violations
// (R6) alarm high: under 3 zeros per 2048 bits
// (R7) coder select: HDB3, B8ZS or AMI by cable
// (R8) encoder takes nrz input; decoder gives violation strobe
// (R9) gated control pins follow only while enable low
// (R10) host keeps gated pins stable while enabled
// (R11) driver fail flag rises on activity time-out
// (R12) serial port independent of line clock
// (R13) transfer starts at select fall, rising-edge sampling
// (R14) host ends write 50 ns after last bit
// (R15) last output bit hold, then output released
// (R16) command LSB first, respond only to address 16
// (R17) write byte: clears, cable, loops, all ones
// (R18) clear bit one clears interrupt and masks source
// (R19) clear bit zero enables that interrupt source
// (R20) loop plus all ones is test request
// (R21) read bits 0-4: flags and cable select
// (R22) read bits 5-7 encode mode or changes
// (R23) output valid edge chosen by edge select
// (R24) interrupt low on unmasked status change
// (R25) both loops written resets all register bits
// (R26) activity time-out parameter, restarts on crossing
// (R27) write commits only after all eight data bits
package lic_pkg;
  // serial frame layout
  localparam logic [5:0] REG_ADDR      = 6'h10;
  localparam logic [4:0] CMD_LAST_BIT  = 5'h07;
  localparam logic [4:0] DATA_FIRST    = 5'h08;
  localparam logic [4:0] DATA_LAST_BIT = 5'h0F;
  localparam logic [4:0] OUT_END_CNT   = 5'h10;
  // write data field positions
  localparam int WB_CLR_NOSIG = 0;
  localparam int WB_CLR_DRV   = 1;
  localparam int WB_CABLE     = 2;
  localparam int WB_REMOTE_LOOP     = 5;
  localparam int WB_LOCAL_LOOP     = 6;
  localparam int WB_ALL_ONES  = 7;
  // line monitoring counts
  localparam logic [10:0] AIS_WIN_LAST  = 11'h7FF;
  localparam logic [1:0]  AIS_MIN_ZEROS = 2'h3;
  localparam logic [7:0]  LOS_ZERO_RUN  = 8'hAF;
  localparam logic [4:0]  LOS_WIN_LAST  = 5'h1F;
  localparam logic [3:0]  LOS_MAX_RUN   = 4'hF;
  localparam logic [1:0]  LOS_ONES      = 2'h3;
  localparam int          DPM_TIMEOUT   = 256;
  // control word kept by the register or the gated pins
  typedef struct packed {
    logic       all_ones;
    logic       local_loop;
    logic       remote_loop;
    logic [2:0] cable;
    logic       tx_ami;
    logic       rx_ami;
  } lic_ctrl_t;
  localparam lic_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1};
  // line code in use
  typedef enum logic [1:0] {
    LIC_CODE_AMI  = 2'b00,
    LIC_CODE_HDB3 = 2'b01,
    LIC_CODE_B8ZS = 2'b10
  } lic_code_t;
  // serial port phases
  typedef enum logic [2:0] {
    LIC_SP_IDLE = 3'b000,
    LIC_SP_CMD  = 3'b001,
    LIC_SP_WR   = 3'b010,
    LIC_SP_RD   = 3'b011,
    LIC_SP_SKIP = 3'b100
  } lic_sp_t;
endpackage

// [test/lic_host_model.sv]
// host controller model driving the serial control port
`timescale 1ns/100ps
`default_nettype none
module lic_host_model (
  // system clock paces the serial clock
  input  wire logic clk_i,
  // serial port
  input  wire logic serial_out_i,
  input  wire logic out_edge_sel_i,
  output logic      ser_clk_o,
  output logic      chip_select_n_o,
  output logic      serial_in_o
);
  // idle port: select high, serial clock still
  initial
  begin
    ser_clk_o       = 1'b0;
    chip_select_n_o = 1'b1;
    serial_in_o     = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  // half a serial period, five system clocks
  task automatic half();
    repeat (5) @(posedge clk_i);
  endtask
  // one frame, cut short after nbits; reply taken lsb first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      input int nbits, output logic [7:0] rd);
    logic [15:0] bits;
    bits = {wd, cmd}; // command then data, lsb first
    rd   = 8'h00;
    @(posedge clk_i);
    chip_select_n_o <= 1'b0; // falling select opens the frame
    for (int i = 0; i < nbits; i++)
    begin
      serial_in_o <= bits[i]; // set up before the rising edge
      half();
      ser_clk_o <= 1'b1;
      if (i > 7 && out_edge_sel_i)
        rd[i-8] = serial_out_i;
      half();
      ser_clk_o <= 1'b0;
      if (i > 7 && !out_edge_sel_i)
        rd[i-8] = serial_out_i;
    end
    half(); // select held 200 ns past the last bit
    chip_select_n_o <= 1'b1;
    serial_in_o     <= ~bits[nbits-1]; // no stale bit once released
    half();
  endtask
endmodule
`default_nettype wire

// [test/line_iface_control_port_test.sv]
// self-checking bench for the line control port
`timescale 1ns/100ps
`default_nettype none
module line_iface_control_port_test;
  // clocks, reset and stimulus
  logic       clk = 1'b0, line_clk = 1'b0, rst = 1'b1;
  logic       pin_ext = 1'b0, latch_n = 1'b1, edge_sel = 1'b1;
  logic       tx_sel = 1'b1, rx_sel = 1'b1, all_ones = 1'b0;
  logic [2:0] cable = 3'h0;
  logic       tx_nrz = 1'b1, ones_run = 1'b0, pol = 1'b0;
  logic       in_p = 1'b0, in_n = 1'b0;
  logic       mon_run = 1'b1, mon_p = 1'b0, mon_n = 1'b0;
  logic       remote_loop_pin = 1'b0;
  logic [7:0] r;
  // never both loops, never loop with all ones
  logic [7:0] modes [3] = '{8'h00, 8'h80, 8'h20};
  // device outputs and serial wires
  wire logic  sck, csn, serial_in, serial_out, sdo_oe, sdo_line, int_oe;
  wire logic  out_p, out_n, nrz_out, alarm, drv_fail, viol, nosig;
  lic_pkg::lic_code_t tx_code, rx_code;
  int         n_errors = 0, num_checks = 0, cycles = 0;

  ////////////////////////////////////////////////////////////////////
  // clocks: line clock offset in phase
  always #20 clk = ~clk;
  initial
  begin
    #3.1;
    forever #7.5 line_clk = ~line_clk;
  end
  // released output shows the inverse of its last bit
  assign sdo_line = sdo_oe ? serial_out : ~serial_out;
  // alternating marks while ones are received
  always @(posedge line_clk)
  begin
    pol  <= ~pol;
    in_p <= ones_run & pol;
    in_n <= ones_run & ~pol;
  end
  // monitor pulses of both polarities with gaps while driver alive
  always @(posedge clk)
    if (mon_run)
    begin
      mon_p <= ~(mon_p | mon_n);
      mon_n <= mon_p;
    end
  // cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////
  lic_line_ctrl #(.DPM_TIMEOUT(16)) lic_line_ctrl_inst (
    .clk_i(clk), .rst_i(rst), .pin_mode_ext_i(pin_ext),
    .ctrl_latch_en_n_i(latch_n), .tx_coder_sel_i(tx_sel),
    .rx_decoder_sel_i(rx_sel), .cable_sel_i(cable),
    .remote_loop_i(remote_loop_pin), .local_loop_i(1'b0),
    .tx_all_ones_i(all_ones),
    .ser_clk_i(sck), .chip_select_n_i(csn), .serial_in_i(serial_in),
    .out_edge_sel_i(edge_sel), .serial_out_o(serial_out), .serial_oe_o(sdo_oe),
    .int_n_out_o(), .int_n_oe_o(int_oe), .line_clk_i(line_clk),
    .tx_nrz_in_i(tx_nrz), .line_in_p_i(in_p), .line_in_n_i(in_n),
    .mon_pos_in_i(mon_p), .mon_neg_in_i(mon_n), .line_out_p_o(out_p),
    .line_out_n_o(out_n), .rx_pos_out_o(), .rx_neg_out_o(),
    .rx_nrz_out_o(nrz_out), .violation_strobe_o(viol),
    .alarm_ind_out_o(alarm), .no_signal_flag_o(nosig),
    .driver_fail_flag_o(drv_fail), .tx_code_o(tx_code),
    .rx_code_o(rx_code)
  );
  lic_host_model lic_host_model_inst (
    .clk_i(clk), .serial_out_i(sdo_line), .out_edge_sel_i(edge_sel),
    .ser_clk_o(sck), .chip_select_n_o(csn), .serial_in_o(serial_in)
  );

  ////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // register write and checked read
  task automatic wr(input logic [7:0] d);
    lic_host_model_inst.xfer(8'h20, d, 16, r);
  endtask
  task automatic rd_chk(input logic [7:0] exp);
    lic_host_model_inst.xfer(8'h21, 8'h00, 16, r);
    check(r, exp);
  endtask
  // count line marks over eight line clocks
  task automatic count_marks(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (8)
    begin
      @(posedge line_clk);
      n = n + {7'h00, out_p | out_n};
    end
    check(n, exp);
    @(posedge clk);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(8'h01);
    for (int i = 0; i < 3; i++)
    begin
      wr(modes[i] | 8'h14);
      rd_chk(modes[i] | 8'h15);
      count_marks(i < 2 ? 8'h08 : 8'h00);
    end
    wr(8'h60);
    rd_chk(8'h01);
    lic_host_model_inst.xfer(8'h20, 8'h1C, 12, r);
    rd_chk(8'h01);
    wr(8'h1C);
    rd_chk(8'h1D);
    wr(8'h00);
    mon_run <= 1'b0;
    repeat (20) @(posedge clk);
    check({6'h00, drv_fail, int_oe}, 8'h03);
    edge_sel <= 1'b0;
    rd_chk(8'hA3);
    check({7'h00, int_oe}, 8'h01);
    edge_sel <= 1'b1;
    wr(8'h02);
    check({7'h00, int_oe}, 8'h00);
    rd_chk(8'h03);
    mon_run <= 1'b1;
    repeat (20) @(posedge clk);
    check({6'h00, drv_fail, int_oe}, 8'h00);
    // pin control, gate open
    pin_ext <= 1'b1;
    latch_n <= 1'b0;
    tx_sel  <= 1'b0;
    rx_sel  <= 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      cable <= c[2:0];
      repeat (10) @(posedge clk);
      if (c != 1)
        check({4'h0, tx_code, rx_code}, c == 0 ? 8'h05 : 8'h0A);
    end
    tx_sel <= 1'b1;
    rx_sel <= 1'b1;
    repeat (10) @(posedge clk);
    check({4'h0, tx_code, rx_code}, 8'h00);
    latch_n <= 1'b1;
    repeat (4) @(posedge clk);
    tx_sel   <= 1'b0;
    rx_sel   <= 1'b0;
    tx_nrz   <= 1'b0;
    all_ones <= 1'b1;
    repeat (10) @(posedge clk);
    check({4'h0, tx_code, rx_code}, 8'h00);
    count_marks(8'h00);
    latch_n <= 1'b0;
    repeat (10) @(posedge clk);
    count_marks(8'h08);
    latch_n <= 1'b1;
    repeat (4) @(posedge clk);
    all_ones <= 1'b0;
    repeat (10) @(posedge clk);
    count_marks(8'h08);
    // remote loop pin overrides all ones
    latch_n   <= 1'b0;
    all_ones  <= 1'b1;
    remote_loop_pin <= 1'b1;
    repeat (10) @(posedge clk);
    count_marks(8'h00);
    ones_run <= 1'b1;
    repeat (4200) @(posedge line_clk);
    check({4'h0, viol, nosig, alarm, nrz_out}, 8'h03);
    count_marks(8'h08);
    ones_run <= 1'b0;
    repeat (4200) @(posedge line_clk);
    check({6'h00, nosig, alarm}, 8'h02);
    end_sim();
  end
endmodule
`default_nettype wire
